// ### cbt_card_bus.sv
// card-side command/response and data-line timing engine
`timescale 1ns/1ps
module cbt_card_bus #(
	parameter int BLK_BYTES = cbt_pkg::BLK_BYTES_DEF
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic card_clk_pin,
	input wire logic cmd_in,
	output logic cmd_out,
	output logic cmd_oe,
	input wire logic dat_in,
	output logic dat_out,
	output logic dat_oe,
	output cbt_pkg::cbt_cmd_s cmd_rx,
	output logic cmd_valid,
	input wire cbt_pkg::cbt_resp_s resp,
	input wire logic [6:0] resp_gap,
	input wire logic resp_req,
	output logic resp_busy,
	input wire logic card_inactive,
	output logic go_idle,
	output logic [15:0] rca,
	input wire logic rca_load,
	input wire logic [15:0] rca_new,
	input wire logic rd_req,
	input wire cbt_pkg::cbt_mode_e rd_mode,
	input wire logic [7:0] rd_byte,
	input wire logic rd_byte_valid,
	output logic rd_byte_ready,
	input wire logic wr_req,
	input wire cbt_pkg::cbt_mode_e wr_mode,
	output logic [7:0] wr_byte,
	output logic wr_byte_valid,
	output logic wr_blk_done,
	output logic wr_blk_ok,
	input wire logic buf_free,
	input wire logic erase_busy,
	output logic xfer_busy
);
	localparam int DBW = $clog2(BLK_BYTES * 8 + 18);
	localparam logic [DBW-1:0] L_DATA = DBW'(BLK_BYTES * 8);
	localparam logic [DBW-1:0] L_END = DBW'(BLK_BYTES * 8 + 16);

	if (BLK_BYTES < 1 || BLK_BYTES > cbt_pkg::BLK_BYTES_MAX)
	begin : g_chk
		$error("block length out of range");
	end

	function automatic logic [6:0] crc7_step(input logic [6:0] c, input logic b);
		return {c[5:0], 1'b0} ^ ((b ^ c[6]) ? cbt_pkg::CRC7_POLY : 7'h00);
	endfunction

	function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic b);
		return {c[14:0], 1'b0} ^ ((b ^ c[15]) ? cbt_pkg::CRC16_POLY : 16'h0000);
	endfunction

	function automatic logic [6:0] crc7_of(input logic [39:0] v);
		logic [6:0] c;
		c = 7'h00;
		for (int i = cbt_pkg::CRC_CMD_BITS - 1; i >= 0; i--)
			c = crc7_step(c, v[i]);
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin sampling: {clock, command, data}; a change counts once stages two and three agree
	logic [2:0] sy1;
	logic [2:0] sy2;
	logic [2:0] sy3;
	logic [2:0] filt;
	logic rise;
	logic fall;
	logic cmd_s;
	logic dat_s;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sy1 <= cbt_pkg::SYNC_RESET;
			sy2 <= cbt_pkg::SYNC_RESET;
			sy3 <= cbt_pkg::SYNC_RESET;
			filt <= cbt_pkg::SYNC_RESET;
		end
		else
		begin
			sy1 <= {card_clk_pin, cmd_in, dat_in};
			sy2 <= sy1;
			sy3 <= sy2;
			filt <= filt ^ (~(sy2 ^ sy3) & (sy3 ^ filt));
		end
	end

	// bits launched on rising edges, sampled mid-bit on falling edges [RULE_11]
	assign rise = sy2[2] & sy3[2] & ~filt[2];
	assign fall = ~sy2[2] & ~sy3[2] & filt[2];
	assign cmd_s = filt[1];
	assign dat_s = filt[0];

	////////////////////////////////////////////////////////////////////////////
	// command receiver, active only while the card is not driving the line
	logic rx_on;
	logic [5:0] rx_cnt;
	logic [45:0] rx_sh;
	logic [6:0] rx_crc;
	logic end_now;
	logic frame_ok;
	logic crc_ok;
	logic stop_now;
	logic [6:0] age;

	assign end_now = fall & ~cmd_oe & rx_on & (rx_cnt == 6'(cbt_pkg::CMD_END_CNT));
	assign frame_ok = end_now & rx_sh[45] & cmd_s; // [RULE_01]
	assign crc_ok = (rx_crc == rx_sh[6:0]); // [RULE_02]
	assign go_idle = frame_ok & crc_ok & (rx_sh[44:39] == cbt_pkg::IDX_GO_IDLE)
		& ~card_inactive; // [RULE_21]
	assign stop_now = frame_ok & crc_ok & (rx_sh[44:39] == cbt_pkg::IDX_STOP);

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_on <= 1'b0;
			rx_cnt <= 6'h00;
			rx_sh <= '0;
			rx_crc <= 7'h00;
		end
		else if (fall && !cmd_oe)
		begin
			if (!rx_on)
			begin
				rx_on <= ~cmd_s;
				rx_cnt <= 6'h01;
				rx_crc <= crc7_step(7'h00, 1'b0);
			end
			else if (rx_cnt == 6'(cbt_pkg::CMD_END_CNT))
				rx_on <= 1'b0;
			else
			begin
				rx_sh <= {rx_sh[44:0], cmd_s};
				rx_cnt <= rx_cnt + 6'h01;
				if (rx_cnt < 6'(cbt_pkg::CRC_CMD_BITS))
					rx_crc <= crc7_step(rx_crc, cmd_s);
			end
		end
	end

	// decoded command handed to the core, data from flip-flops
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cmd_rx <= '0;
			cmd_valid <= 1'b0;
		end
		else
		begin
			cmd_valid <= frame_ok;
			if (frame_ok)
				cmd_rx <= '{index: rx_sh[44:39], arg: rx_sh[38:7], crc_ok: crc_ok};
		end
	end

	// rising edges since the last command end bit, saturating
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			age <= cbt_pkg::AGE_SAT;
		else if (end_now)
			age <= 7'h00;
		else if (rise && age != cbt_pkg::AGE_SAT)
			age <= age + 7'h01;
	end

	////////////////////////////////////////////////////////////////////////////
	// response transmitter on the command line
	typedef enum logic [1:0] {R_IDLE, R_WAIT, R_TX} cbt_rstate_e;
	cbt_rstate_e rstate;
	logic [47:0] tx_sh;
	logic [5:0] tx_cnt;
	logic [6:0] gap;
	logic ident;
	logic resp_start;
	logic [6:0] next_gap;

	// open-drain identification replies use a fixed gap; others are clamped
	always_comb
	begin
		if (resp.ident)
			next_gap = cbt_pkg::IDENT_GAP; // [RULE_05]
		else if (resp_gap < cbt_pkg::RESP_GAP_MIN)
			next_gap = cbt_pkg::RESP_GAP_MIN; // [RULE_04]
		else if (resp_gap > cbt_pkg::RESP_GAP_MAX)
			next_gap = cbt_pkg::RESP_GAP_MAX; // [RULE_04]
		else
			next_gap = resp_gap;
	end

	assign resp_start = rise & (rstate == R_WAIT) & (age >= gap);
	assign resp_busy = (rstate != R_IDLE);

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rstate <= R_IDLE;
			tx_sh <= '0;
			tx_cnt <= 6'h00;
			gap <= cbt_pkg::RESP_GAP_MIN;
			ident <= 1'b0;
			cmd_out <= 1'b1;
			cmd_oe <= 1'b0;
		end
		else if (go_idle)
		begin
			rstate <= R_IDLE;
			cmd_oe <= 1'b0; // [RULE_22]
		end
		else
		begin
			case (rstate)
				R_IDLE:
				begin
					if (resp_req)
					begin
						// start 0, direction 0, payload, check field, end 1
						tx_sh <= {2'b00, resp.index, resp.arg,
							crc7_of({2'b00, resp.index, resp.arg}), 1'b1}; // [RULE_01] [RULE_02]
						gap <= next_gap;
						ident <= resp.ident;
						rstate <= R_WAIT;
					end
				end
				R_WAIT:
				begin
					if (resp_start)
					begin
						cmd_out <= 1'b0; // [RULE_04]
						cmd_oe <= 1'b1;
						tx_sh <= {tx_sh[46:0], 1'b0};
						tx_cnt <= 6'h01;
						rstate <= R_TX;
					end
					else if (rise)
					begin
						// first cycle floats; then pull-ups are driven, never in open-drain
						cmd_out <= 1'b1;
						cmd_oe <= ~ident & (age != 7'h00); // [RULE_12] [RULE_03]
					end
				end
				R_TX:
				begin
					if (rise)
					begin
						if (tx_cnt == 6'(cbt_pkg::CMD_BITS))
						begin
							cmd_oe <= 1'b0; // [RULE_24]
							rstate <= R_IDLE;
						end
						else
						begin
							cmd_out <= tx_sh[47];
							cmd_oe <= ident ? ~tx_sh[47] : 1'b1;
							tx_sh <= {tx_sh[46:0], 1'b0};
							tx_cnt <= tx_cnt + 6'h01;
						end
					end
				end
				default:
					rstate <= R_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data line: read blocks/stream, write blocks/stream, status token, busy
	typedef enum logic [2:0] {D_IDLE, D_RGAP, D_RTX, D_WWAIT, D_WRX, D_WSTAT, D_BUSY}
		cbt_dstate_e;
	cbt_dstate_e dstate;
	cbt_pkg::cbt_mode_e dmode;
	logic dwrite;
	logic [DBW-1:0] dcnt;
	logic [DBW-1:0] next_dcnt;
	logic [7:0] bsh;
	logic [15:0] dcrc;
	logic [15:0] rcrc;
	logic [2:0] stat;
	logic [2:0] scnt;
	logic pflag;
	logic busy_hold;
	logic rd_go;
	logic byte_bound;

	assign busy_hold = ~buf_free | erase_busy;
	assign byte_bound = (dcnt[2:0] == 3'h0) & (dcnt < L_DATA);
	assign rd_go = rise & (dstate == D_RGAP) & (age >= cbt_pkg::READ_GAP_MIN) & rd_byte_valid;
	assign rd_byte_ready = rise & (dstate == D_RTX) & byte_bound;
	assign xfer_busy = (dstate != D_IDLE);
	// streams count bits within a byte only, so they never reach the check field
	assign next_dcnt = (dmode == cbt_pkg::DM_STREAM) ? DBW'(dcnt[2:0] + 3'h1)
		: dcnt + 1'b1; // [RULE_15]

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dstate <= D_IDLE;
			dmode <= cbt_pkg::DM_BLOCK;
			dwrite <= 1'b0;
			dcnt <= '0;
			bsh <= 8'h00;
			dcrc <= 16'h0000;
			rcrc <= 16'h0000;
			stat <= cbt_pkg::STAT_OK;
			scnt <= 3'h0;
			pflag <= 1'b0;
			dat_out <= 1'b1;
			dat_oe <= 1'b0;
			wr_byte <= 8'h00;
			wr_byte_valid <= 1'b0;
			wr_blk_done <= 1'b0;
			wr_blk_ok <= 1'b0;
		end
		else
		begin
			wr_byte_valid <= 1'b0;
			wr_blk_done <= 1'b0;
			if (go_idle)
			begin
				dstate <= D_IDLE;
				dat_oe <= 1'b0; // [RULE_21] [RULE_22]
			end
			else if (stop_now && dstate != D_IDLE && dstate != D_BUSY)
			begin
				// halts at the stop end bit; an open write goes on to programming busy
				dat_oe <= 1'b0; // [RULE_14] [RULE_13]
				pflag <= 1'b0;
				dmode <= cbt_pkg::DM_BLOCK;
				dstate <= dwrite ? D_BUSY : D_IDLE;
			end
			else
			begin
				case (dstate)
					D_IDLE:
					begin
						dcnt <= '0;
						dcrc <= 16'h0000;
						pflag <= 1'b0;
						if (rd_req)
						begin
							dmode <= rd_mode;
							dwrite <= 1'b0;
							dstate <= D_RGAP;
						end
						else if (wr_req)
						begin
							dmode <= wr_mode;
							dwrite <= 1'b1;
							dstate <= D_WWAIT;
						end
						else if (rise && erase_busy)
						begin
							dmode <= cbt_pkg::DM_BLOCK;
							dwrite <= 1'b0;
							dstate <= D_BUSY; // [RULE_20]
						end
					end
					D_RGAP:
					begin
						if (rd_go)
						begin
							dat_out <= 1'b0; // [RULE_06]
							dat_oe <= 1'b1;
							dcnt <= '0;
							dcrc <= 16'h0000;
							dstate <= D_RTX;
						end
					end
					D_RTX:
					begin
						if (rise)
						begin
							if (dcnt < L_DATA)
							begin
								dat_out <= byte_bound ? rd_byte[7] : bsh[7];
								bsh <= byte_bound ? {rd_byte[6:0], 1'b0} : {bsh[6:0], 1'b0};
								dcrc <= crc16_step(dcrc, byte_bound ? rd_byte[7] : bsh[7]);
								dcnt <= next_dcnt;
							end
							else if (dcnt < L_END)
							begin
								dat_out <= dcrc[15];
								dcrc <= {dcrc[14:0], 1'b0};
								dcnt <= dcnt + 1'b1;
							end
							else if (dcnt == L_END)
							begin
								dat_out <= 1'b1;
								dcnt <= dcnt + 1'b1;
							end
							else
							begin
								// single block ends alone; multi-block goes round again
								dat_oe <= 1'b0; // [RULE_24]
								dstate <= (dmode == cbt_pkg::DM_MULTI) ? D_RGAP : D_IDLE; // [RULE_13]
							end
						end
					end
					D_WWAIT:
					begin
						// a refused block must leave the line to the host's retry
						if (rise)
							dat_oe <= 1'b0; // [RULE_24]
						dcnt <= '0;
						dcrc <= 16'h0000;
						if (fall && !dat_s)
							dstate <= D_WRX;
					end
					D_WRX:
					begin
						if (fall)
						begin
							dcnt <= (dcnt < L_DATA) ? next_dcnt : dcnt + 1'b1;
							if (dcnt < L_DATA)
							begin
								bsh <= {bsh[6:0], dat_s};
								dcrc <= crc16_step(dcrc, dat_s);
								if (dcnt[2:0] == 3'h7)
								begin
									wr_byte <= {bsh[6:0], dat_s};
									wr_byte_valid <= 1'b1;
								end
							end
							else if (dcnt < L_END)
								rcrc <= {rcrc[14:0], dat_s};
							else
							begin
								stat <= (rcrc == dcrc) ? cbt_pkg::STAT_OK : cbt_pkg::STAT_BAD;
								wr_blk_ok <= (rcrc == dcrc);
								wr_blk_done <= 1'b1;
								scnt <= 3'h0;
								dstate <= D_WSTAT; // [RULE_16]
							end
						end
					end
					D_WSTAT:
					begin
						if (rise)
						begin
							scnt <= scnt + 3'h1;
							case (scnt)
								3'h0: dat_oe <= 1'b0;
								3'h1:
								begin
									dat_out <= 1'b0;
									dat_oe <= 1'b1;
								end
								3'h2: dat_out <= stat[2];
								3'h3: dat_out <= stat[1];
								3'h4: dat_out <= stat[0];
								default:
								begin
									dat_out <= 1'b1;
									pflag <= 1'b0;
									// good block: programming busy; bad block: await the retry
									dstate <= (stat == cbt_pkg::STAT_OK) ? D_BUSY : D_WWAIT; // [RULE_16]
								end
							endcase
						end
					end
					D_BUSY:
					begin
						if (rise)
						begin
							if (busy_hold)
							begin
								dat_out <= 1'b0; // [RULE_17] [RULE_20]
								dat_oe <= 1'b1;
							end
							else if (!pflag)
							begin
								dat_out <= 1'b1; // [RULE_03]
								dat_oe <= 1'b1;
								pflag <= 1'b1;
							end
							else
							begin
								dat_oe <= 1'b0; // [RULE_24]
								dstate <= (dwrite && dmode == cbt_pkg::DM_MULTI) ? D_WWAIT : D_IDLE;
							end
						end
					end
					default:
						dstate <= D_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// relative card address, default after power-on and software reset
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			rca <= cbt_pkg::RCA_DEFAULT;
		else if (go_idle)
			rca <= cbt_pkg::RCA_DEFAULT; // [RULE_22]
		else if (rca_load)
			rca <= rca_new;
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions
	property p_resp_window;
		@(posedge ref_clk) disable iff (!rst_b)
		resp_start && !ident |-> age >= 7'h02 && age <= 7'h40;
	endproperty
	a_resp_window: assert property (p_resp_window) else $error("response gap out of range"); // [RULE_04]

	property p_ident_gap;
		@(posedge ref_clk) disable iff (!rst_b)
		resp_start && ident |-> age == 7'h05;
	endproperty
	a_ident_gap: assert property (p_ident_gap) else $error("identification gap not five"); // [RULE_05]

	property p_start_bit;
		@(posedge ref_clk) disable iff (!rst_b)
		resp_start && !go_idle |=> cmd_oe && !cmd_out && rstate == R_TX;
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("response start bit missing"); // [RULE_01]

	property p_float_then_pull;
		@(posedge ref_clk) disable iff (!rst_b)
		rstate == R_WAIT && !ident && age >= 7'h02 && !go_idle |-> cmd_oe && cmd_out;
	endproperty
	a_float_then_pull: assert property (p_float_then_pull) else $error("pull-up not driven"); // [RULE_12]

	property p_read_gap;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(dat_oe) && dstate == D_RTX |-> !dat_out && $past(age) >= 7'h02;
	endproperty
	a_read_gap: assert property (p_read_gap) else $error("read data started too early"); // [RULE_06]

	property p_stop;
		@(posedge ref_clk) disable iff (!rst_b)
		stop_now && dstate == D_RTX |=> !dat_oe && dstate == D_IDLE;
	endproperty
	a_stop: assert property (p_stop) else $error("data not halted by stop"); // [RULE_14]

	property p_busy_low;
		@(posedge ref_clk) disable iff (!rst_b)
		dstate == D_BUSY && rise && busy_hold && !go_idle |=> dat_oe && !dat_out;
	endproperty
	a_busy_low: assert property (p_busy_low) else $error("busy not held low"); // [RULE_17]

	property p_reset_state;
		@(posedge ref_clk) disable iff (!rst_b)
		go_idle |=> rca == 16'h0001 && !cmd_oe && !dat_oe;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("soft reset incomplete"); // [RULE_22]

	property p_status_token;
		@(posedge ref_clk) disable iff (!rst_b)
		dstate == D_WSTAT && rise && scnt == 3'h3 |=> dat_oe && dat_out == wr_blk_ok;
	endproperty
	a_status_token: assert property (p_status_token) else $error("bad status pattern"); // [RULE_16]
endmodule

// ### cbt_pkg.sv
// constants and carrier types for the card bus command/data timing engine
// Notes on behaviour
// RULE_01: frames open with start 0, direction bit (host 1, card 0), close with 1.
// RULE_02: sender puts a seven-bit check field just before the end bit.
// RULE_03: a pull-up bit is actively driven high, not left to the resistor; open-drain identification replies release it instead.
// RULE_04: card response starts 2 to 64 cycles after the command end.
// RULE_05: identification responses start exactly 5 cycles after the command.
// RULE_06: read data starts at least 2 cycles after the command end bit.
// RULE_07: host waits at least 8 cycles after a response before commanding.
// RULE_08: host waits at least 8 cycles after an unanswered command.
// RULE_09: after an unanswered last identification command, host adds 136 cycles.
// RULE_10: host starts write data at least 2 cycles after the response.
// RULE_11: commands and responses are launched on the rising clock edge.
// RULE_12: card floats the line one cycle, then drives pull-ups until start; identification replies float the whole gap instead.
// RULE_13: single-block read stops alone; multi-block and stream run until stop.
// RULE_14: stop command ends data transmission at its end bit.
// RULE_15: stream transfers carry no checksum and return no write status.
// RULE_16: after each write block card returns status 010 good or 101 bad.
// RULE_17: card holds data low while no receive buffer is free.
// RULE_18: host polls status instead of trusting busy release as success.
// RULE_19: host selects card, sets block length, then issues block write.
// RULE_20: card holds data busy until all tagged sectors are erased.
// RULE_21: software reset returns card to idle except when inactive.
// RULE_22: after reset outputs float and relative address becomes 0x0001.
// RULE_23: host reports a missing response start bit as a timeout.
// RULE_24: each party releases the line at the end of its own frame.
package cbt_pkg;
	localparam int CMD_BITS = 48;
	localparam int CRC_CMD_BITS = 40;
	localparam int CMD_END_CNT = 47;
	localparam logic [6:0] RESP_GAP_MIN = 7'h02;
	localparam logic [6:0] RESP_GAP_MAX = 7'h40;
	localparam logic [6:0] IDENT_GAP = 7'h05;
	localparam logic [6:0] READ_GAP_MIN = 7'h02;
	localparam logic [6:0] AGE_SAT = 7'h7f;
	localparam logic [5:0] IDX_GO_IDLE = 6'h00;
	localparam logic [5:0] IDX_STOP = 6'h0c;
	localparam logic [15:0] RCA_DEFAULT = 16'h0001;
	localparam logic [2:0] STAT_OK = 3'h2;
	localparam logic [2:0] STAT_BAD = 3'h5;
	localparam logic [6:0] CRC7_POLY = 7'h09;
	localparam logic [15:0] CRC16_POLY = 16'h1021;
	localparam logic [2:0] SYNC_RESET = 3'h3;
	localparam int BLK_BYTES_DEF = 512;
	localparam int BLK_BYTES_MAX = 2048;

	typedef enum logic [1:0] {DM_BLOCK, DM_MULTI, DM_STREAM} cbt_mode_e;

	typedef struct packed {
		logic [5:0] index;
		logic [31:0] arg;
		logic crc_ok;
	} cbt_cmd_s;

	typedef struct packed {
		logic [5:0] index;
		logic [31:0] arg;
		logic ident;
	} cbt_resp_s;
endpackage

// ### cbt_host_model.sv
// host-side partner: bus clock plus command and data line drivers
`timescale 1ns/1ps
module cbt_host_model (
	input wire logic ref_clk,
	input wire logic cmd_w,
	input wire logic dat_w,
	input wire logic c_cmd_oe,
	input wire logic c_dat_oe,
	output logic card_clk,
	output logic h_cmd,
	output logic h_cmd_oe,
	output logic h_dat,
	output logic h_dat_oe
);
	logic s_cmd, s_cmdoe, s_dat, s_datoe;

	// lines start released, so the pull-ups hold them high
	initial
	begin
		card_clk = 1'b0;
		h_cmd = 1'b1;
		h_cmd_oe = 1'b0;
		h_dat = 1'b1;
		h_dat_oe = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// msb-first check sum of the low n bits of d, w bits wide
	function automatic logic [15:0] crc(input logic [63:0] d, input int n, input int w,
		input logic [15:0] p);
		logic [15:0] c;
		logic [16:0] m;
		m = (17'h1 << w) - 17'h1;
		c = 16'h0000;
		for (int i = n - 1; i >= 0; i--)
		begin
			c = ((c << 1) & m[15:0]) ^ ((d[i] ^ c[w - 1]) ? p : 16'h0000);
		end
		return c;
	endfunction

	// one bus cycle; the clock stands low between calls, so it is still outside frames
	task automatic cyc(input logic c, input logic ce, input logic d, input logic de);
		@(posedge ref_clk);
		#1;
		card_clk = 1'b1; // lines change with the rising bus edge
		h_cmd = c;
		h_cmd_oe = ce;
		h_dat = d;
		h_dat_oe = de;
		repeat (8) @(posedge ref_clk);
		#1;
		s_cmd = cmd_w;
		s_cmdoe = c_cmd_oe;
		s_dat = dat_w;
		s_datoe = c_dat_oe;
		repeat (2) @(posedge ref_clk);
		#1;
		card_clk = 1'b0;
		repeat (9) @(posedge ref_clk);
		#1; // whatever the caller drives next lands off the edge
	endtask

	// command frame: start 0, host direction 1, index, argument, check field, end 1
	task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg, input logic bad);
		logic [47:0] f;
		logic [15:0] c;
		f = {2'b01, idx, arg, 8'h00};
		c = crc({24'h0, f[47:8]}, 40, 7, 16'h0009);
		f[7:0] = {c[6:0] ^ {6'h00, bad}, 1'b1};
		repeat (8) cyc(1'b1, 1'b0, 1'b1, 1'b0); // released gap
		for (int i = 47; i >= 0; i--)
		begin
			cyc(f[i], 1'b1, 1'b1, 1'b0); // ones are driven, not left to the pull-up
		end
	endtask
endmodule

// ### card_bus_cmd_data_timing_tb.sv
// self-checking bench for the card bus timing engine
`timescale 1ns/1ps
`define CHK(a, b, m) \
	begin \
		samples_checked++; \
		if ((a) !== (b)) \
		begin \
			n_fail++; \
			$display("CHECK FAILED t=%0t %s", $time, m); \
		end \
	end
module card_bus_cmd_data_timing_tb;
	typedef struct {
		logic [5:0] idx;
		logic [31:0] arg;
		logic bad;
		logic [6:0] gap;
		logic ident;
	} cbt_row_s;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic cmd_w, dat_w, card_clk, h_cmd, h_cmd_oe, h_dat, h_dat_oe;
	logic cmd_out, cmd_oe, dat_out, dat_oe, cmd_valid, resp_busy, go_idle, rd_byte_ready;
	logic wr_byte_valid, wr_blk_done, wr_blk_ok, xfer_busy, resp_req = 1'b0;
	logic card_inactive = 1'b0, rca_load = 1'b0, rd_req = 1'b0, wr_req = 1'b0;
	logic buf_free = 1'b1, erase_busy = 1'b0, rd_byte_valid = 1'b1;
	logic [6:0] resp_gap = 7'h02;
	logic [15:0] rca;
	logic [15:0] rca_new = 16'h5a3c;
	logic [7:0] rd_byte, wr_byte;
	logic [4:0] st;
	cbt_pkg::cbt_cmd_s cmd_rx;
	cbt_pkg::cbt_resp_s resp = '0;
	cbt_pkg::cbt_mode_e rd_mode = cbt_pkg::DM_BLOCK;
	cbt_pkg::cbt_mode_e wr_mode = cbt_pkg::DM_BLOCK;
	int n_fail = 0;
	int samples_checked = 0;
	int n_val = 0, n_idle = 0, n_rdy = 0, n_blk = 0, v0;
	logic [7:0] wq[$];
	cbt_row_s rows[5] = '{
		'{6'h03, 32'h1234_5678, 1'b0, 7'h02, 1'b0},
		'{6'h0d, 32'hffff_ffff, 1'b0, 7'h40, 1'b0},
		'{6'h02, 32'h8000_0001, 1'b0, 7'h1e, 1'b1},
		'{6'h10, 32'h0000_0000, 1'b0, 7'h7f, 1'b0},
		'{6'h11, 32'h0a0a_0a0a, 1'b1, 7'h02, 1'b0}};

	// clock, pulled-up lines and the read byte source
	always #4 ref_clk = ~ref_clk;
	assign cmd_w = cmd_oe ? cmd_out : (h_cmd_oe ? h_cmd : 1'b1);
	assign dat_w = dat_oe ? dat_out : (h_dat_oe ? h_dat : 1'b1);
	assign rd_byte = n_rdy[7:0] ^ 8'h96;

	// pulse counters; non-blocking so the byte source never races the engine
	always @(posedge ref_clk)
	begin
		if (cmd_valid) n_val <= n_val + 1;
		if (go_idle) n_idle <= n_idle + 1;
		if (rd_byte_ready) n_rdy <= n_rdy + 1;
		if (wr_byte_valid) wq.push_back(wr_byte);
		if (wr_blk_done) n_blk <= n_blk + 1;
	end

	cbt_card_bus #(.BLK_BYTES(2)) cbt_card_bus_i (.ref_clk, .rst_b, .card_clk_pin(card_clk),
		.cmd_in(cmd_w), .cmd_out, .cmd_oe, .dat_in(dat_w), .dat_out, .dat_oe, .cmd_rx,
		.cmd_valid, .resp, .resp_gap, .resp_req, .resp_busy, .card_inactive, .go_idle, .rca,
		.rca_load, .rca_new, .rd_req, .rd_mode, .rd_byte, .rd_byte_valid, .rd_byte_ready,
		.wr_req, .wr_mode, .wr_byte, .wr_byte_valid, .wr_blk_done, .wr_blk_ok, .buf_free,
		.erase_busy, .xfer_busy);
	cbt_host_model hm (.ref_clk, .cmd_w, .dat_w, .c_cmd_oe(cmd_oe), .c_dat_oe(dat_oe),
		.card_clk, .h_cmd, .h_cmd_oe, .h_dat, .h_dat_oe);

	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic idle_cyc();
		hm.cyc(1'b1, 1'b0, 1'b1, 1'b0);
	endtask

	// bounded wait for busy to end; a timeout goes straight to the verdict
	task automatic wait_rel();
		int k;
		k = 0;
		do
		begin
			idle_cyc();
			k++;
		end
		while (hm.s_dat !== 1'b1 && k < 20);
		`CHK(k < 20, 1'b1, "busy never ended")
		if (k >= 20) finish_test();
		idle_cyc();
		`CHK(hm.s_datoe, 1'b0, "data not released")
	endtask

	// request a response, then walk the command line one bus cycle at a time
	task automatic do_resp(input cbt_row_s r);
		logic [48:0] fr;
		logic [15:0] c;
		int eg;
		eg = r.ident ? 5 : (r.gap < 2 ? 2 : (r.gap > 64 ? 64 : int'(r.gap)));
		resp = {r.idx, ~r.arg, r.ident};
		resp_gap = r.gap;
		resp_req = 1'b1;
		tick(1);
		resp_req = 1'b0;
		`CHK(resp_busy, 1'b1, "response request not taken")
		for (int k = 1; k <= eg + 49; k++)
		begin
			idle_cyc();
			fr = {fr[47:0], hm.s_cmd};
			if (k == 1 || k == eg + 49)
				`CHK(hm.s_cmdoe, 1'b0, "line not released")
			else if (k <= eg)
				`CHK({hm.s_cmd, hm.s_cmdoe}, {1'b1, ~r.ident}, "gap bits")
		end
		c = hm.crc({24'h0, fr[48:9]}, 40, 7, 16'h0009);
		`CHK(fr[48:47], 2'b00, "start moment or direction")
		`CHK(fr[46:9], {r.idx, ~r.arg}, "response payload")
		`CHK(fr[8:1], {c[6:0], 1'b1}, "check field or end")
		`CHK(resp_busy, 1'b0, "response engine not closed")
	endtask

	// read in one mode; two-byte blocks make a missing or extra check field visible
	task automatic do_read(input cbt_pkg::cbt_mode_e m);
		logic [32:0] d;
		logic [23:0] e;
		logic [15:0] c;
		int k, n0;
		hm.send_cmd(6'h11, 32'h0, 1'b0);
		n0 = n_rdy;
		rd_mode = m;
		rd_req = 1'b1;
		tick(1);
		rd_req = 1'b0;
		k = 0;
		do
		begin
			idle_cyc();
			k++;
		end
		while (hm.s_dat !== 1'b0 && k < 12);
		`CHK(k >= 3 && k < 12, 1'b1, "read start moment")
		if (k >= 12) finish_test();
		for (int i = 0; i < 33; i++)
		begin
			idle_cyc();
			d = {d[31:0], hm.s_dat};
		end
		e = {8'(n0) ^ 8'h96, 8'(n0 + 1) ^ 8'h96, 8'(n0 + 2) ^ 8'h96};
		c = hm.crc({48'h0, e[23:8]}, 16, 16, cbt_pkg::CRC16_POLY);
		if (m == cbt_pkg::DM_STREAM)
			`CHK(d[32:9], e, "stream bits")
		else
			`CHK(d, {e[23:8], c, 1'b1}, "block bits")
		if (m == cbt_pkg::DM_BLOCK)
		begin
			idle_cyc();
			`CHK({hm.s_datoe, xfer_busy}, 2'b00, "block read went on")
		end
		else
		begin
			`CHK(xfer_busy, 1'b1, "read ended before stop")
			hm.send_cmd(cbt_pkg::IDX_STOP, 32'h0, 1'b0);
			`CHK({dat_oe, xfer_busy}, 2'b00, "data after stop")
		end
	endtask

	// send a two-byte block, then collect the five-bit status frame
	task automatic do_write(input logic bad);
		logic [15:0] c;
		logic [31:0] f;
		hm.send_cmd(6'h07, 32'h0001_0000, 1'b0); // select, block length, write
		hm.send_cmd(6'h10, 32'h0000_0002, 1'b0);
		hm.send_cmd(6'h18, 32'h0000_0200, 1'b0);
		c = hm.crc({48'h0, 16'hc35a}, 16, 16, cbt_pkg::CRC16_POLY);
		f = {16'hc35a, c ^ {15'h0, bad}};
		wr_req = 1'b1;
		tick(1);
		wr_req = 1'b0;
		repeat (2) idle_cyc();
		hm.cyc(1'b1, 1'b0, 1'b0, 1'b1);
		for (int i = 31; i >= 0; i--)
		begin
			hm.cyc(1'b1, 1'b0, f[i], 1'b1);
		end
		hm.cyc(1'b1, 1'b0, 1'b1, 1'b1);
		for (int k = 1; k <= 6; k++)
		begin
			idle_cyc();
			st = {st[3:0], hm.s_dat};
			if (k == 1) `CHK(hm.s_datoe, 1'b0, "no float before status")
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// reset, command table, then soft reset, reads, writes and erase busy
	initial
	begin
		repeat (20) @(posedge ref_clk);
		`CHK({cmd_oe, dat_oe, rca}, {2'b00, cbt_pkg::RCA_DEFAULT}, "reset state")
		#1;
		rst_b = 1'b1;
		tick(5);
		foreach (rows[i])
		begin
			v0 = n_val;
			hm.send_cmd(rows[i].idx, rows[i].arg, rows[i].bad);
			`CHK(n_val, v0 + 1, "command not flagged")
			`CHK(cmd_rx, {rows[i].idx, rows[i].arg, ~rows[i].bad}, "command fields")
			if (!rows[i].bad) do_resp(rows[i]);
			else
				repeat (136)
				begin
					idle_cyc(); // unanswered: 136 released cycles, each checked for silence, before the next command
					`CHK(hm.s_cmdoe, 1'b0, "reply to a refused command")
				end
		end
		rca_load = 1'b1;
		tick(1);
		rca_load = 1'b0;
		card_inactive = 1'b1;
		v0 = n_idle;
		hm.send_cmd(cbt_pkg::IDX_GO_IDLE, 32'h0, 1'b0);
		`CHK({n_idle == v0, rca}, {1'b1, rca_new}, "reset while inactive")
		card_inactive = 1'b0;
		hm.send_cmd(cbt_pkg::IDX_GO_IDLE, 32'h0, 1'b0);
		`CHK({n_idle == v0 + 1, rca}, {1'b1, cbt_pkg::RCA_DEFAULT}, "soft reset")
		do_read(cbt_pkg::DM_BLOCK);
		do_read(cbt_pkg::DM_MULTI);
		do_read(cbt_pkg::DM_STREAM);
		do_write(1'b1);
		`CHK({st, wr_blk_ok}, 6'b010110, "error status")
		buf_free = 1'b0;
		do_write(1'b0);
		`CHK({st, wr_blk_ok}, 6'b001011, "good status")
		`CHK({wq[$ - 1], wq[$]}, 16'hc35a, "written bytes")
		`CHK(n_blk, 2, "block end pulses")
		repeat (4)
		begin
			idle_cyc();
			`CHK({hm.s_dat, hm.s_datoe}, 2'b01, "no busy hold")
		end
		buf_free = 1'b1;
		wait_rel();
		hm.send_cmd(6'h0d, 32'h0001_0000, 1'b0); // the outcome comes from a status poll
		`CHK(cmd_rx.index, 6'h0d, "status poll not taken")
		erase_busy = 1'b1;
		idle_cyc();
		repeat (3)
		begin
			idle_cyc();
			`CHK({hm.s_dat, hm.s_datoe}, 2'b01, "no erase busy")
		end
		erase_busy = 1'b0;
		wait_rel();
		finish_test();
	end
endmodule
